// *** dic_cmd_engine.sv ***
`default_nettype none

// Overview of operation
// - NACK unimplemented address or bad command combination
// - error state leaves only on a Start
// - volatile register updates on final data bit
// - Stop or Start mid word discards word
// - lock bit set blocks volatile write
// - output register follows DAC while latch low
// - NV write without high voltage acked, ignored
// - NV cycle starts only after terminating Stop
// - volatile access continues during NV cycle
// - byte after NV write cancels it, NACKs
// - NV write during NV cycle is error
// - continuous volatile writes until Stop or Start
// - continuous NV write is error, nothing stored
// - status flag shows NV cycle running
// - address pointer kept across Start and Stop
// - reads ignore high voltage pin level
// - latch high reads return output value
// - continuous reads end on host NACK
// - invalid command releases data line passively
// - type 00 writes, 11 reads, else invalid
// - five address bits select the location
// - reset clears state and address pointer
// - client address 11000 plus select pins
module dic_cmd_engine
    import dic_pkg::*;
#(
    parameter int unsigned NV_WC_CYCLES = NV_WRITE_CYCLES
) (
    input  wire logic                           clk_sys_i,
    input  wire logic                           nrst_i,
    input  wire logic                           clk_scl_i,
    input  wire logic                           sda_i,
    input  wire logic                           high_voltage_enable_pin_i,
    input  wire logic [NUM_CH-1:0]              output_latch_pin_i,
    input  wire logic [1:0]                     address_select_pins_i,
    input  wire logic [NUM_VOL-1:0]             lock_bits_i,
    output logic                                sda_o,
    output logic                                sda_oe_o,
    output logic [NUM_CH-1:0][WORD_W-1:0]       dac_output_o,
    output logic                                nv_write_active_flag_o
);

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    logic                link_clr;
    logic                link_tog;
    logic                link_bit;
    logic                next_link_tog;
    dic_pins_t           pin_raw;
    dic_pins_t           pin_s1;
    dic_pins_t           pin_s2;
    dic_pins_t           pin_prev;
    dic_evt_t            evt;
    dic_state_t          state;
    dic_state_t          next_state;
    logic [3:0]          bitcnt;
    logic [3:0]          next_bitcnt;
    logic [7:0]          sreg;
    logic [7:0]          next_sreg;
    logic [7:0]          word_hi;
    logic [7:0]          next_word_hi;
    logic                byte_idx;
    logic                next_byte_idx;
    logic [ADDR_W-1:0]   ptr;
    logic [ADDR_W-1:0]   next_ptr;
    logic                ack_pend;
    logic                next_ack_pend;
    logic [WORD_W-1:0]   rd_word;
    logic [WORD_W-1:0]   next_rd_word;
    logic                next_oe;
    logic                nv_pend;
    logic                next_nv_pend;
    logic [WORD_W-1:0]   nv_data;
    logic [WORD_W-1:0]   next_nv_data;
    logic [ADDR_W-1:0]   nv_addr;
    logic [ADDR_W-1:0]   next_nv_addr;
    logic [NV_CNT_W-1:0] nv_cnt;
    logic [NV_CNT_W-1:0] next_nv_cnt;
    logic                nv_busy;
    logic                nv_go;
    logic                nv_commit;
    logic                vol_we;
    logic [WORD_W-1:0]   vol_wd;
    logic [WORD_W-1:0]   rd_sel;
    logic [7:0]          byte_in;
    logic                cmd_done;
    logic [WORD_W-1:0]   vol_mem [NUM_VOL];
    logic [WORD_W-1:0]   nv_mem  [NUM_NV];

    // link side: sample data on scl rise, flag each bit by a toggle
    always_comb begin
        next_link_tog = ~link_tog;
    end

    always_ff @(posedge clk_scl_i or posedge link_clr) begin
        if (link_clr) begin
            link_tog <= 1'b0;
            link_bit <= 1'b0;
        end else begin
            link_tog <= next_link_tog;
            link_bit <= sda_i;
        end
    end

    // holds the link flops cleared while the system is in reset
    always_ff @(posedge clk_sys_i) begin
        link_clr <= ~nrst_i;
    end

    // pins and the bit toggle pass two flops, a third keeps history
    assign pin_raw = '{scl:   clk_scl_i,
                       sda:   sda_i,
                       tog:   link_tog,
                       hv:    high_voltage_enable_pin_i,
                       latch: output_latch_pin_i,
                       asel:  address_select_pins_i,
                       lock:  lock_bits_i};

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            pin_s1   <= '0;
            pin_s2   <= '0;
            pin_prev <= '0;
        end else begin
            pin_s1   <= pin_raw;
            pin_s2   <= pin_s1;
            pin_prev <= pin_s2;
        end
    end

    // start, stop, bit arrival and scl fall
    always_comb begin
        evt.start    = pin_prev.scl & pin_s2.scl & pin_prev.sda & ~pin_s2.sda;
        evt.stop     = pin_prev.scl & pin_s2.scl & ~pin_prev.sda & pin_s2.sda;
        evt.bit_ev   = pin_prev.tog ^ pin_s2.tog;
        evt.bit_val  = link_bit;
        evt.scl_fall = pin_prev.scl & ~pin_s2.scl;
    end

    // read data source for the pointed location
    always_comb begin
        rd_sel = '0;
        if (dic_is_vol(ptr)) begin
            if (ptr < ADDR_W'(NUM_CH) && pin_s2.latch[ptr[2:0]]) begin
                rd_sel = dac_output_o[ptr[2:0]];
            end else begin
                rd_sel = vol_mem[ptr[3:0]];
            end
        end else if (ptr == ADDR_STATUS) begin
            rd_sel[STATUS_NV_BIT] = nv_busy;
        end else if (dic_is_nv(ptr) && !nv_busy) begin
            rd_sel = nv_mem[ptr[3:0]];
        end
    end

    assign byte_in  = {sreg[6:0], evt.bit_val};
    assign cmd_done = evt.bit_ev && !evt.start && !evt.stop
                      && state == ST_CMD && bitcnt == BYTE_BITS - 4'h1;
    assign vol_wd   = {word_hi, byte_in};

    // command interpreter next state
    always_comb begin
        next_state    = state;
        next_bitcnt   = bitcnt;
        next_sreg     = sreg;
        next_word_hi  = word_hi;
        next_byte_idx = byte_idx;
        next_ptr      = ptr;
        next_ack_pend = ack_pend;
        next_rd_word  = rd_word;
        next_oe       = sda_oe_o;
        next_nv_pend  = nv_pend;
        next_nv_data  = nv_data;
        vol_we        = 1'b0;
        nv_go         = 1'b0;
        if (evt.start) begin
            // discard any partial word, keep the pointer
            next_state    = ST_CTRL;
            next_bitcnt   = '0;
            next_byte_idx = 1'b0;
            next_ack_pend = 1'b0;
            next_nv_pend  = 1'b0;
        end else if (evt.stop) begin
            nv_go         = state == ST_NVSTOP && nv_pend;
            next_bitcnt   = '0;
            next_byte_idx = 1'b0;
            next_ack_pend = 1'b0;
            next_nv_pend  = 1'b0;
            if (state != ST_ERROR) begin
                next_state = ST_IDLE;
            end
        end else if (evt.bit_ev) begin
            if (bitcnt == BYTE_BITS) begin
                // acknowledge slot
                next_bitcnt = '0;
                if (ack_pend) begin
                    next_ack_pend = 1'b0;
                end else if (state == ST_RDATA) begin
                    if (evt.bit_val) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_byte_idx = ~byte_idx;
                        if (byte_idx) begin
                            next_rd_word = rd_sel;
                        end
                    end
                end
            end else begin
                next_sreg   = byte_in;
                next_bitcnt = bitcnt + 4'h1;
                if (bitcnt == BYTE_BITS - 4'h1) begin
                    unique case (state)
                        ST_IDLE: begin
                        end
                        ST_CTRL: begin
                            if (byte_in[7:1] == {CLIENT_ADDR_HI,
                                                 pin_s2.asel}) begin
                                next_ack_pend = 1'b1;
                                if (byte_in[0]) begin
                                    next_state    = ST_RDATA;
                                    next_byte_idx = 1'b0;
                                    next_rd_word  = rd_sel;
                                end else begin
                                    next_state = ST_CMD;
                                end
                            end else begin
                                next_state = ST_IDLE;
                            end
                        end
                        ST_CMD: begin
                            // address in 7:3, type in 2:1, bit 0 ignored
                            if (byte_in[2:1] == CMD_WRITE) begin
                                if (!(dic_is_vol(byte_in[7:3])
                                      || dic_is_nv(byte_in[7:3]))) begin
                                    next_state = ST_ERROR;
                                end else if (dic_is_nv(byte_in[7:3])
                                             && nv_busy) begin
                                    next_state = ST_ERROR;
                                end else begin
                                    next_ptr      = byte_in[7:3];
                                    next_ack_pend = 1'b1;
                                    next_state    = ST_WDATA;
                                    next_byte_idx = 1'b0;
                                end
                            end else if (byte_in[2:1] == CMD_READ) begin
                                if (!(dic_is_vol(byte_in[7:3])
                                      || dic_is_nv(byte_in[7:3])
                                      || byte_in[7:3] == ADDR_STATUS)) begin
                                    next_state = ST_ERROR;
                                end else if (dic_is_nv(byte_in[7:3])
                                             && nv_busy) begin
                                    next_state = ST_ERROR;
                                end else begin
                                    next_ptr      = byte_in[7:3];
                                    next_ack_pend = 1'b1;
                                end
                            end else begin
                                next_state = ST_ERROR;
                            end
                        end
                        ST_WDATA: begin
                            next_ack_pend = 1'b1;
                            if (!byte_idx) begin
                                next_word_hi  = byte_in;
                                next_byte_idx = 1'b1;
                            end else begin
                                next_byte_idx = 1'b0;
                                if (dic_is_nv(ptr)) begin
                                    next_state   = ST_NVSTOP;
                                    next_nv_pend = pin_s2.hv;
                                    next_nv_data = vol_wd;
                                end else begin
                                    next_state = ST_CMD;
                                    vol_we = !pin_s2.lock[ptr[3:0]];
                                end
                            end
                        end
                        ST_RDATA: begin
                        end
                        ST_NVSTOP: begin
                            next_state   = ST_ERROR;
                            next_nv_pend = 1'b0;
                        end
                        ST_ERROR: begin
                            next_state = ST_ERROR;
                        end
                    endcase
                end
            end
        end
        // data line changes on scl fall, and is released on start or stop while scl is high
        if (evt.start || evt.stop) begin
            next_oe = 1'b0;
        end else if (evt.scl_fall) begin
            if (bitcnt == BYTE_BITS) begin
                next_oe = ack_pend;
            end else begin
                next_oe = state == ST_RDATA && !ack_pend
                          && !rd_word[{~byte_idx, ~bitcnt[2:0]}];
            end
        end
    end

    // command interpreter registers
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state    <= ST_IDLE;
            bitcnt   <= '0;
            sreg     <= '0;
            word_hi  <= '0;
            byte_idx <= 1'b0;
            ptr      <= ADDR_PTR_RESET;
            ack_pend <= 1'b0;
            rd_word  <= '0;
            sda_oe_o <= 1'b0;
            sda_o    <= 1'b0;
            nv_pend  <= 1'b0;
            nv_data  <= '0;
        end else begin
            state    <= next_state;
            bitcnt   <= next_bitcnt;
            sreg     <= next_sreg;
            word_hi  <= next_word_hi;
            byte_idx <= next_byte_idx;
            ptr      <= next_ptr;
            ack_pend <= next_ack_pend;
            rd_word  <= next_rd_word;
            sda_oe_o <= next_oe;
            sda_o    <= 1'b0;
            nv_pend  <= next_nv_pend;
            nv_data  <= next_nv_data;
        end
    end

    // nonvolatile write cycle timer
    always_comb begin
        next_nv_addr = nv_addr;
        next_nv_cnt  = nv_cnt;
        if (nv_go) begin
            next_nv_addr = ptr;
            next_nv_cnt  = NV_CNT_W'(NV_WC_CYCLES);
        end else if (nv_busy) begin
            next_nv_cnt = nv_cnt - NV_CNT_W'(1);
        end
    end

    assign nv_busy   = nv_cnt != '0;
    assign nv_commit = nv_cnt == NV_CNT_W'(1);

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            nv_addr                <= '0;
            nv_cnt                 <= '0;
            nv_write_active_flag_o <= 1'b0;
        end else begin
            nv_addr                <= next_nv_addr;
            nv_cnt                 <= next_nv_cnt;
            nv_write_active_flag_o <= next_nv_cnt != '0;
        end
    end

    // storage and output registers, one flop group per entry
    for (genvar g = 0; g < NUM_VOL; g++) begin : g_vol
        always_ff @(posedge clk_sys_i) begin
            if (!nrst_i) begin
                vol_mem[g] <= VOL_RESET;
            end else if (vol_we && ptr[3:0] == 4'(g)) begin
                vol_mem[g] <= vol_wd;
            end
        end
    end

    for (genvar g = 0; g < NUM_NV; g++) begin : g_nv
        always_ff @(posedge clk_sys_i) begin
            if (!nrst_i) begin
                nv_mem[g] <= NV_RESET;
            end else if (nv_commit && nv_addr[3:0] == 4'(g)) begin
                nv_mem[g] <= nv_data;
            end
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : g_out
        always_ff @(posedge clk_sys_i) begin
            if (!nrst_i) begin
                dac_output_o[g] <= VOL_RESET;
            end else if (!pin_s2.latch[g]) begin
                dac_output_o[g] <= vol_mem[g];
            end
        end
    end

    // checks
    sequence s_abort;
        state == ST_WDATA && (evt.start || evt.stop);
    endsequence

    sequence s_stop_pend;
        evt.stop && state == ST_NVSTOP && nv_pend;
    endsequence

    AST_NACK_BAD_CMD: assert property (
        cmd_done && byte_in[2:1] != CMD_WRITE && byte_in[2:1] != CMD_READ
        |=> state == ST_ERROR && !ack_pend ##1 !sda_oe_o || state != ST_ERROR)
        else $error("bad command type was acknowledged");
    AST_ERROR_STAYS: assert property (
        state == ST_ERROR && !evt.start |=> state == ST_ERROR)
        else $error("error state left without a start");
    AST_WORD_ON_LAST_BIT: assert property (
        vol_we |-> state == ST_WDATA && byte_idx && evt.bit_ev
                   && bitcnt == BYTE_BITS - 4'h1)
        else $error("volatile write outside final data bit");
    AST_ABORT_NO_WRITE: assert property (
        s_abort |=> !byte_idx && bitcnt == 4'h0)
        else $error("partial word survived a start or stop");
    AST_LOCK_BLOCKS: assert property (
        vol_we |-> !pin_s2.lock[ptr[3:0]])
        else $error("write to a locked location");
    AST_LATCH_COPY: assert property (
        !pin_s2.latch[0] |=> dac_output_o[0] == $past(vol_mem[0]))
        else $error("output register missed latch copy");
    AST_HV_GATES_NV: assert property (
        $rose(nv_pend) |-> $past(pin_s2.hv))
        else $error("nonvolatile write armed without high voltage");
    AST_NV_AFTER_STOP: assert property (
        s_stop_pend |=> nv_busy ##1 nv_write_active_flag_o)
        else $error("nonvolatile cycle did not start on stop");
    AST_NV_ONLY_ON_STOP: assert property (
        $rose(nv_busy) |-> $past(evt.stop))
        else $error("nonvolatile cycle started without stop");
    AST_NV_BUSY_ERROR: assert property (
        cmd_done && nv_busy && byte_in[2:1] == CMD_WRITE
        && dic_is_nv(byte_in[7:3]) |=> state == ST_ERROR && !ack_pend)
        else $error("nonvolatile write during cycle not refused");
    AST_CONT_NV_ERROR: assert property (
        state == ST_NVSTOP && evt.bit_ev && !evt.start && !evt.stop
        && bitcnt == BYTE_BITS - 4'h1 |=> state == ST_ERROR && !nv_pend)
        else $error("byte after nonvolatile write not refused");
    AST_PTR_KEPT: assert property (
        evt.start || evt.stop |=> ptr == $past(ptr))
        else $error("pointer changed on start or stop");

endmodule : dic_cmd_engine

`default_nettype wire

// *** dic_host_model.sv ***
`default_nettype none
// bus host: scl made from the link clock, sda only pulled low
module dic_host_model (
    input  wire logic clk_link_i,
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus: both lines released high, scl stands still
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // third of a bit, keeps each scl phase above 150 ns
    task automatic tick();
        repeat (16) @(posedge clk_link_i);
    endtask
    // start or repeated start
    task automatic start();
        sda_low_o = 1'b0;
        tick();
        scl_o = 1'b1;
        tick();
        sda_low_o = 1'b1;
        tick();
        scl_o = 1'b0;
    endtask
    // stop, then bus released
    task automatic stop();
        tick();
        sda_low_o = 1'b1;
        tick();
        scl_o = 1'b1;
        tick();
        sda_low_o = 1'b0;
        tick();
    endtask
    // one clock: sda changed only while scl low
    task automatic clk_bit(input logic low, output logic seen);
        tick();
        sda_low_o = low;
        tick();
        scl_o = 1'b1;
        tick();
        seen = sda_i;
        scl_o = 1'b0;
    endtask
    // byte out msb first, ack sampled in ninth clock
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(!b[i], s);
        end
        clk_bit(1'b0, s);
        ack = !s;
    endtask
    // byte in, then host ack (low) or nack
    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, b[i]);
        end
        clk_bit(ack, s);
    endtask
endmodule // dic_host_model
`default_nettype wire

// *** dic_pkg.sv ***
`default_nettype none

package dic_pkg;

    // timing
    localparam int unsigned CLK_SYS_PERIOD_NS      = 25;
    localparam int unsigned NV_WRITE_CYCLE_TIME_NS = 10_000_000;
    localparam int unsigned NV_WRITE_CYCLES        =
        (NV_WRITE_CYCLE_TIME_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
    localparam int unsigned NV_CNT_W               = 24;

    // sizes and field positions
    localparam int unsigned ADDR_W        = 5;
    localparam int unsigned WORD_W        = 16;
    localparam int unsigned NUM_CH        = 8;
    localparam int unsigned NUM_VOL       = 10;
    localparam int unsigned NUM_NV        = 10;
    localparam int unsigned STATUS_NV_BIT = 6;

    // addresses, codes and reset values
    localparam logic [4:0]  CLIENT_ADDR_HI = 5'h18;
    localparam logic [1:0]  CMD_WRITE      = 2'h0;
    localparam logic [1:0]  CMD_READ       = 2'h3;
    localparam logic [4:0]  ADDR_STATUS    = 5'h0A;
    localparam logic [4:0]  ADDR_PTR_RESET = 5'h00;
    localparam logic [3:0]  NV_ENTRIES     = 4'hA;
    localparam logic [3:0]  BYTE_BITS      = 4'h8;
    localparam logic [15:0] VOL_RESET      = 16'h0000;
    localparam logic [15:0] NV_RESET       = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CTRL, ST_CMD, ST_WDATA, ST_RDATA, ST_NVSTOP, ST_ERROR
    } dic_state_t;

    // pin levels sampled into the system clock
    typedef struct packed {
        logic               scl;
        logic               sda;
        logic               tog;
        logic               hv;
        logic [NUM_CH-1:0]  latch;
        logic [1:0]         asel;
        logic [NUM_VOL-1:0] lock;
    } dic_pins_t;

    // bus conditions seen in the system clock
    typedef struct packed {
        logic start;
        logic stop;
        logic bit_ev;
        logic bit_val;
        logic scl_fall;
    } dic_evt_t;

    function automatic logic dic_is_vol(input logic [4:0] a);
        return a < ADDR_STATUS;
    endfunction

    function automatic logic dic_is_nv(input logic [4:0] a);
        return a[4] && (a[3:0] < NV_ENTRIES);
    endfunction

endpackage : dic_pkg

`default_nettype wire

// *** tb.sv ***
`default_nettype none
// bench: host model on the bus, pins driven from here
module tb import dic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                          clk_sys, clk_link, nrst, hv, scl;
    logic                          sda, sda_low, sda_o, sda_oe, nv_flag;
    logic [NUM_CH-1:0]             latch;
    logic [NUM_VOL-1:0]            lock;
    logic [1:0]                    asel;
    logic [NUM_CH-1:0][WORD_W-1:0] dac;
    int                            fails = 0;
    int                            checks = 0;
    // pulled-up wire, low when either party pulls
    assign sda = !(sda_low || (sda_oe && !sda_o));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = !clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #3.7;
        forever #6 clk_link = !clk_link;
    end
    dic_cmd_engine #(.NV_WC_CYCLES(6000)) dic_cmd_engine_i (
        .clk_sys_i(clk_sys), .nrst_i(nrst), .clk_scl_i(scl),
        .sda_i(sda), .high_voltage_enable_pin_i(hv),
        .output_latch_pin_i(latch), .address_select_pins_i(asel),
        .lock_bits_i(lock), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .dac_output_o(dac), .nv_write_active_flag_o(nv_flag));
    dic_host_model host_i (.clk_link_i(clk_link), .sda_i(sda),
        .scl_o(scl), .sda_low_o(sda_low));
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // pin change just after a system clock edge
    task automatic sys_step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    function automatic logic [7:0] ctl(input logic rw);
        return {CLIENT_ADDR_HI, 2'b01, rw};
    endfunction
    // single write, acks of all four bytes returned
    task automatic wr(input logic [4:0] a, input logic [15:0] d,
                      output logic [3:0] ak);
        host_i.start();
        host_i.put_byte(ctl(1'b0), ak[3]);
        host_i.put_byte({a, CMD_WRITE, 1'b0}, ak[2]);
        host_i.put_byte(d[15:8], ak[1]);
        host_i.put_byte(d[7:0], ak[0]);
        host_i.stop();
    endtask
    // addressed read: write control, command, repeated start
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        logic k;
        host_i.start();
        host_i.put_byte(ctl(1'b0), k);
        host_i.put_byte({a, CMD_READ, 1'b0}, k);
        host_i.start();
        host_i.put_byte(ctl(1'b1), k);
        host_i.get_byte(1'b1, d[15:8]);
        host_i.get_byte(1'b0, d[7:0]);
        host_i.stop();
    endtask
    // write, read back, then a word cut short by stop
    task automatic t_write_abort();
        logic [3:0]  ak;
        logic [15:0] d;
        wr(5'h08, 16'hA53C, ak);
        check("write acks", 16'(ak), 16'h000F);
        rd(5'h08, d);
        check("volatile word", d, 16'hA53C);
        host_i.start();
        host_i.put_byte(ctl(1'b0), ak[0]);
        host_i.put_byte({5'h08, CMD_WRITE, 1'b0}, ak[0]);
        host_i.put_byte(8'h11, ak[0]);
        host_i.stop();
        rd(5'h08, d);
        check("aborted word", d, 16'hA53C);
    endtask
    // bad type, held off until a repeated start
    task automatic t_bad_cmd();
        logic [3:0] ak;
        host_i.start();
        host_i.put_byte(ctl(1'b0), ak[3]);
        host_i.put_byte({5'h08, 2'b01, 1'b0}, ak[2]);
        host_i.put_byte(8'h00, ak[1]);
        host_i.start();
        host_i.put_byte(ctl(1'b0), ak[0]);
        host_i.stop();
        check("bad command acks", 16'(ak), 16'h0009);
        host_i.start();
        host_i.put_byte({5'h19, 2'b01, 1'b0}, ak[0]);
        host_i.stop();
        check("foreign address ack", 16'(ak[0]), 16'h0000);
        sys_step(1);
        asel = 2'b11;
        host_i.start();
        host_i.put_byte(ctl(1'b0), ak[1]);
        host_i.stop();
        check("select pins ack", 16'(ak[1]), 16'h0000);
        sys_step(1);
        asel = 2'b01;
    endtask
    // lock blocks, latch high holds output
    task automatic t_lock_latch();
        logic [3:0]  ak;
        logic [15:0] d;
        sys_step(1);
        lock[9] = 1'b1;
        wr(5'h09, 16'h1234, ak);
        rd(5'h09, d);
        check("locked word", d, VOL_RESET);
        wr(5'h00, 16'h0F0F, ak);
        check("output held", dac[0], VOL_RESET);
        rd(5'h00, d);
        check("read while latched", d, VOL_RESET);
        sys_step(1);
        latch[0] = 1'b0;
        sys_step(8);
        check("output copied", dac[0], 16'h0F0F);
    endtask
    // nonvolatile write with volatile traffic during the cycle
    task automatic t_nv();
        logic [3:0]  ak;
        logic [15:0] d;
        int          n;
        wr(5'h11, 16'hBEEF, ak);
        check("nv acks without hv", 16'(ak), 16'h000F);
        check("no cycle without hv", 16'(nv_flag), 16'h0000);
        sys_step(1);
        hv = 1'b1;
        wr(5'h10, 16'h00FF, ak);
        sys_step(8);
        check("nv flag set", 16'(nv_flag), 16'h0001);
        rd(ADDR_STATUS, d);
        check("status bit", 16'(d[STATUS_NV_BIT]), 16'h0001);
        wr(5'h11, 16'h1111, ak);
        check("nv write in cycle", 16'(ak), 16'h0008);
        wr(5'h08, 16'h5555, ak);
        check("vol acks in cycle", 16'(ak), 16'h000F);
        n = 0;
        while (nv_flag !== 1'b0 && n < 9000) begin
            sys_step(1);
            n++;
        end
        check("nv flag cleared", 16'(nv_flag), 16'h0000);
        rd(5'h10, d);
        check("nv word", d, 16'h00FF);
        host_i.start();
        host_i.put_byte(ctl(1'b1), ak[0]);
        host_i.get_byte(1'b1, d[15:8]);
        host_i.get_byte(1'b0, d[7:0]);
        host_i.stop();
        check("last address word", d, 16'h00FF);
        rd(5'h11, d);
        check("nv word without hv", d, NV_RESET);
        host_i.start();
        host_i.put_byte(ctl(1'b0), ak[3]);
        host_i.put_byte({5'h10, CMD_WRITE, 1'b0}, ak[2]);
        host_i.put_byte(8'h12, ak[1]);
        host_i.put_byte(8'h34, ak[0]);
        host_i.put_byte(8'h56, ak[0]);
        host_i.stop();
        check("nv continuous acks", 16'(ak), 16'h000E);
        check("nv write cancelled", 16'(nv_flag), 16'h0000);
    endtask
    initial begin
        nrst = 1'b0;
        hv = 1'b0;
        latch = '1;
        lock = '0;
        asel = 2'b01;
        sys_step(3);
        nrst = 1'b1;
        sys_step(8);
        t_write_abort();
        t_bad_cmd();
        t_lock_latch();
        t_nv();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
